//--- rrag_cfg.svh
// Constants of the raster refresh address generator: offsets, fields,
// reset values and counts. Included by every design file that needs them.
`ifndef RRAG_CFG_SVH
`define RRAG_CFG_SVH

// Register byte offsets (word aligned, Avalon-MM byte address)
`define RRAG_OFF_CTRL 5'h00
`define RRAG_OFF_XPT 5'h04
`define RRAG_OFF_YPT 5'h08
`define RRAG_OFF_XORG 5'h0c
`define RRAG_OFF_YORG 5'h10
`define RRAG_OFF_MOVE 5'h14
`define RRAG_OFF_MEMOP 5'h18
`define RRAG_OFF_STAT 5'h1c

// Field positions
`define RRAG_EQ_LSB 0
`define RRAG_EQ_MSB 3
`define RRAG_COORD_MSB 11
`define RRAG_STAT_REFUSED 0

// Reset values
`define RRAG_CTRL_RST 4'h0
`define RRAG_MEMOP_RST 2'h0

// Timing and counting figures
`define RRAG_LINE_LIMIT 4'hc
`define RRAG_BCD_LAST 4'h9
`define RRAG_OP_NOP 2'h3

// Backplane key codes {key_a, key_b}; any other code means high resolution
`define RRAG_KEY_LOW 2'h0
`define RRAG_KEY_MED 2'h1

`endif

//--- rrag_pkg.sv
// Types of the raster refresh address generator.
// Assumes rrag_cfg.svh supplies the numeric constants.
package rrag_pkg;

    // Update equation: step enables and directions per axis
    typedef struct packed {
        logic y_up;
        logic y_en;
        logic x_up;
        logic x_en;
    } rrag_eq_t;

    // Select signals from the memory timing generator
    typedef struct packed {
        logic access_vs_refresh_select;
        logic row_col_select_a;
        logic row_col_select_b;
    } rrag_tgen_t;

    typedef enum logic [1:0] {
        RES_LOW,
        RES_MED,
        RES_HIGH
    } rrag_res_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } rrag_bus_st_t;

endpackage : rrag_pkg

//--- rrag_xmap.sv
// X coordinate mapping: binary X into the mixed low/decimal/upper format.
// Assumes a binary coordinate below 640; larger values map to garbage.
`timescale 1ns/1ps

module rrag_xmap
    import rrag_pkg::*;
(
    input wire logic [9:0] i_coord,
    output logic [9:0] o_mixed
);

    logic [3:0] rom_lo [256];
    logic [3:0] rom_hi [256];
    logic [7:0] idx;

    // Two lowest bits are already correct in both formats
    assign idx = i_coord[9:2];

    // Constant tables: quotient and remainder of the index by five
    for (genvar a = 0; a < 256; a++) begin : g_rom
        localparam int Q = a / 5;
        localparam int R = a % 5;
        assign rom_lo[a] = {Q[0], R[2:0]};
        assign rom_hi[a] = Q[4:1];
    end

    assign o_mixed = {rom_hi[idx], rom_lo[idx], i_coord[1:0]};

endmodule : rrag_xmap

//--- rrag_core.sv
// Refresh memory address generator: operating point counters, origins,
// screen refresh counters and row/column address multiplexing.
// Assumes sequencer, sync and timing-generator inputs share i_clk_sys,
// which runs at the system half clock; only the backplane keys are async.
//
// Notes on behaviour
// - Update equation from control register, from bus bits on move loads.
// - Equation plus per-axis step pulses give count pulse and direction.
// - X point is one binary bit, one decimal digit, five binary bits.
// - X point lowest bit ignored except in highest resolution.
// - X point load takes the mapped X coordinate.
// - Each step moves the addressed point counter by one, X point by two below highest resolution.
// - Six low X point bits go out; four upper bits to multiplexer.
// - Y point is a 12-bit up/down counter loaded from doubler.
// - Field bit of Y point goes straight to memories.
// - First stage picks operating-point or refresh 12-bit address.
// - Second stage sends the address as row then column halves.
// - Row/column select is the AND of two timing selects.
// - Coordinates pass unchanged or shifted one place up.
// - Low doubles both axes, medium only Y, high neither.
// - X coordinates are mapped into the mixed format.
// - Two X bits pass directly; the rest address two lookup tables.
// - Y origin takes doubled value and feeds Y refresh counter.
// - X origin takes mapped value; its low bit picks line parity.
// - Refresh counters preset from origins in blanking intervals.
// - X refresh counter advances each half clock during the line.
// - X refresh low digit is timing; next bit out; top four muxed.
// - Two-bit code picks refresh, read, write or no-access cycle.
// - X origin loads at most once per twelve scan lines.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps

`include "rrag_cfg.svh"

module rrag_core
    import rrag_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [4:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_x_step_pulse,
    input wire logic i_y_step_pulse,
    input wire logic i_resolution_key_a,
    input wire logic i_resolution_key_b,
    input wire logic i_hblank_preset,
    input wire logic i_vblank_preset,
    input wire rrag_tgen_t i_tgen,
    output logic [5:0] o_x_element_addr,
    output logic o_access_field_bit,
    output logic o_line_parity_bit,
    output logic [3:0] o_state_timing,
    output logic o_refresh_addr_bit,
    output logic [5:0] o_ram_addr,
    output logic [1:0] o_cycle_code
);

    // Step the mixed value; skip_lo steps at the decimal digit
    function automatic logic [9:0] mix_step(
        input logic [9:0] v,
        input logic up,
        input logic skip_lo
    );
        logic lo;
        logic [3:0] d;
        logic [4:0] hi;
        logic c;
        lo = v[0];
        d = v[4:1];
        hi = v[9:5];
        c = 1'b1;
        if (!skip_lo) begin
            c = up ? lo : ~lo;
            lo = ~lo;
        end
        if (c) begin
            if (up) begin
                if (d >= `RRAG_BCD_LAST) begin
                    d = 4'h0;
                    hi = hi + 5'h01;
                end else begin
                    d = d + 4'h1;
                end
            end else begin
                if (d == 4'h0) begin
                    d = `RRAG_BCD_LAST;
                    hi = hi - 5'h01;
                end else begin
                    d = d - 4'h1;
                end
            end
        end
        return {hi, d, lo};
    endfunction : mix_step

    rrag_bus_st_t bus_st_r;
    rrag_eq_t ctrl_r;
    rrag_eq_t eq_sel;
    rrag_res_t res;
    logic [1:0] key_s1_r;
    logic [1:0] key_s2_r;
    logic [9:0] x_point_r;
    logic [11:0] y_point_r;
    logic [9:0] x_origin_r;
    logic [11:0] y_origin_r;
    logic [8:0] xr_r;
    logic [7:0] yr_r;
    logic [3:0] line_cnt_r;
    logic hblank_d_r;
    logic refused_r;
    logic [1:0] memop_r;
    logic acc;
    logic wr_acc;
    logic dbl;
    logic x_count_pulse;
    logic x_count_direction;
    logic y_count_pulse;
    logic y_count_direction;
    logic x_point_load;
    logic y_point_load;
    logic x_scroll_load;
    logic y_scroll_load;
    logic move_load;
    logic line_start;
    logic [11:0] coord;
    logic [9:0] x_mapped;
    logic [11:0] op_addr;
    logic [11:0] rf_addr;
    logic [11:0] chosen;
    logic col_sel;
    logic [31:0] rd_mux;
    logic [9:0] xr_step;

    // Backplane keys come from jumpers outside this clock domain
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            key_s1_r <= 2'h0;
            key_s2_r <= 2'h0;
        end else begin
            key_s1_r <= {i_resolution_key_a, i_resolution_key_b};
            key_s2_r <= key_s1_r;
        end
    end

    always_comb begin
        unique case (key_s2_r)
            `RRAG_KEY_LOW: res = RES_LOW;
            `RRAG_KEY_MED: res = RES_MED;
            default: res = RES_HIGH;
        endcase
    end

    // Avalon-MM slave: one wait cycle, access takes effect on release
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus_st_r <= BUS_IDLE;
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0;
        end else begin
            unique case (bus_st_r)
                BUS_IDLE: if (i_read || i_write) begin
                    bus_st_r <= BUS_ACK;
                    o_waitrequest <= 1'b0;
                    o_readdata <= i_read ? rd_mux : 32'h0;
                end
                BUS_ACK: begin
                    bus_st_r <= BUS_IDLE;
                    o_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    assign acc = (bus_st_r == BUS_ACK);
    assign wr_acc = acc && i_write && i_byteenable[0];
    assign x_point_load = wr_acc && (i_address == `RRAG_OFF_XPT);
    assign y_point_load = wr_acc && (i_address == `RRAG_OFF_YPT);
    assign x_scroll_load = wr_acc && (i_address == `RRAG_OFF_XORG);
    assign y_scroll_load = wr_acc && (i_address == `RRAG_OFF_YORG);
    assign move_load = wr_acc && (i_address == `RRAG_OFF_MOVE);

    always_comb begin
        unique case (i_address)
            `RRAG_OFF_CTRL: rd_mux = {28'h0, ctrl_r};
            `RRAG_OFF_XPT: rd_mux = {22'h0, x_point_r};
            `RRAG_OFF_YPT: rd_mux = {20'h0, y_point_r};
            `RRAG_OFF_XORG: rd_mux = {22'h0, x_origin_r};
            `RRAG_OFF_YORG: rd_mux = {20'h0, y_origin_r};
            `RRAG_OFF_MEMOP: rd_mux = {28'h0, o_cycle_code, memop_r};
            `RRAG_OFF_STAT: rd_mux = {24'h0, line_cnt_r, 1'b0, res,
                                      refused_r};
            default: rd_mux = 32'h0;
        endcase
    end

    // Control register and next memory cycle code
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_r <= `RRAG_CTRL_RST;
            memop_r <= `RRAG_MEMOP_RST;
        end else if (wr_acc && i_address == `RRAG_OFF_CTRL) begin
            ctrl_r <= i_writedata[`RRAG_EQ_MSB:`RRAG_EQ_LSB];
        end else if (wr_acc && i_address == `RRAG_OFF_MEMOP) begin
            memop_r <= i_writedata[1:0];
        end
    end

    assign eq_sel = move_load ? rrag_eq_t'(i_writedata[3:0]) : ctrl_r;
    assign x_count_pulse = i_x_step_pulse && eq_sel.x_en;
    assign x_count_direction = eq_sel.x_up;
    assign y_count_pulse = i_y_step_pulse && eq_sel.y_en;
    assign y_count_direction = eq_sel.y_up;

    // doubling by one place toward the top
    assign dbl = (res == RES_LOW) ||
                 (res == RES_MED && !move_is_x(i_address));
    assign coord = dbl ? {i_writedata[10:0], 1'b0}
                       : i_writedata[`RRAG_COORD_MSB:0];

    // axis indicator: address as argument keeps the assign sensitive
    function automatic logic move_is_x(input logic [4:0] a);
        return (a == `RRAG_OFF_XPT) || (a == `RRAG_OFF_XORG);
    endfunction : move_is_x

    // mapped X value from lookup tables
    rrag_xmap u_xmap (
        .i_coord(coord[9:0]),
        .o_mixed(x_mapped)
    );

    // X operating point; load wins over a step
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            x_point_r <= 10'h000;
        end else if (x_point_load) begin
            // low bit dropped below highest resolution
            x_point_r <= {x_mapped[9:1], (res == RES_HIGH) & x_mapped[0]};
        end else if (x_count_pulse) begin
            x_point_r <= mix_step(x_point_r, x_count_direction,
                                  res != RES_HIGH);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            y_point_r <= 12'h000;
        end else if (y_point_load) begin
            y_point_r <= coord;
        end else if (y_count_pulse) begin
            y_point_r <= y_count_direction ? y_point_r + 12'h001
                                           : y_point_r - 12'h001;
        end
    end

    assign line_start = i_hblank_preset && !hblank_d_r;

    // line counter since last X origin load, saturating
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hblank_d_r <= 1'b0;
            line_cnt_r <= `RRAG_LINE_LIMIT;
        end else begin
            hblank_d_r <= i_hblank_preset;
            if (x_scroll_load && line_cnt_r >= `RRAG_LINE_LIMIT) begin
                line_cnt_r <= 4'h0;
            end else if (line_start && line_cnt_r < `RRAG_LINE_LIMIT) begin
                line_cnt_r <= line_cnt_r + 4'h1;
            end
        end
    end

    // X origin, early loads refused and flagged
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            x_origin_r <= 10'h000;
            refused_r <= 1'b0;
        end else if (x_scroll_load) begin
            if (line_cnt_r >= `RRAG_LINE_LIMIT) begin
                x_origin_r <= x_mapped;
            end else begin
                refused_r <= 1'b1;
            end
        end else if (wr_acc && i_address == `RRAG_OFF_STAT &&
                     i_writedata[`RRAG_STAT_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            y_origin_r <= 12'h000;
        end else if (y_scroll_load) begin
            y_origin_r <= coord;
        end
    end

    // X refresh counter, decimal digit at the bottom
    assign xr_step = mix_step({xr_r, 1'b0}, 1'b1, 1'b1);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            xr_r <= 9'h000;
        end else if (i_hblank_preset) begin
            xr_r <= x_origin_r[9:1];
        end else begin
            xr_r <= xr_step[9:1];
        end
    end

    // Y refresh counter, one line per blanking start
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            yr_r <= 8'h00;
        end else if (i_vblank_preset) begin
            yr_r <= y_origin_r[7:0];
        end else if (line_start) begin
            yr_r <= yr_r + 8'h01;
        end
    end

    // code latched at the last state of each cycle
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cycle_code <= `RRAG_OP_NOP;
        end else if (i_hblank_preset) begin
            // No access while the counter is reloaded in blanking
            o_cycle_code <= `RRAG_OP_NOP;
        end else if (xr_r[3:0] == `RRAG_BCD_LAST) begin
            o_cycle_code <= memop_r;
        end
    end

    assign op_addr = {y_point_r[8:1], x_point_r[9:6]};
    assign rf_addr = {yr_r, xr_r[8:5]};
    assign chosen = i_tgen.access_vs_refresh_select ? op_addr : rf_addr;
    assign col_sel = i_tgen.row_col_select_a && i_tgen.row_col_select_b;

    // row then column half to the RAMs
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ram_addr <= 6'h00;
        end else begin
            o_ram_addr <= col_sel ? chosen[11:6] : chosen[5:0];
        end
    end

    assign o_x_element_addr = x_point_r[5:0];
    assign o_access_field_bit = y_point_r[0];
    assign o_line_parity_bit = x_origin_r[0];
    assign o_state_timing = xr_r[3:0];
    assign o_refresh_addr_bit = xr_r[4];

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    sequence seq_ack;
        !o_waitrequest ##1 o_waitrequest;
    endsequence

    AST_BUS_ONE_WAIT: assert property (
        bus_st_r == BUS_IDLE && (i_read || i_write) |=> seq_ack)
        else $error("bus answer not after one wait cycle");
    AST_X_NO_STEP: assert property (
        i_x_step_pulse && !eq_sel.x_en && !x_point_load |=>
        $stable(x_point_r))
        else $error("x point moved without enable");
    AST_Y_STEP_UP: assert property (
        y_count_pulse && y_count_direction && !y_point_load |=>
        y_point_r == $past(y_point_r) + 12'h001)
        else $error("y point did not step up by one");
    AST_X_LSB_IGNORED: assert property (
        x_point_load && res != RES_HIGH |=> !x_point_r[0])
        else $error("x low bit set below high resolution");
    AST_X_PRESET: assert property (
        i_hblank_preset |=> xr_r == $past(x_origin_r[9:1]))
        else $error("x refresh not preset from origin");
    AST_BCD_WRAP: assert property (
        !i_hblank_preset && xr_r[3:0] == `RRAG_BCD_LAST |=>
        xr_r[3:0] == 4'h0)
        else $error("refresh digit did not wrap");
    AST_XORG_LIMIT: assert property (
        x_scroll_load && line_cnt_r < `RRAG_LINE_LIMIT |=>
        $stable(x_origin_r) && refused_r)
        else $error("x origin loaded too soon");
    AST_COL_HALF: assert property (
        col_sel |=> o_ram_addr == $past(chosen[11:6]))
        else $error("column half not sent");
    AST_NOP_BLANK: assert property (
        i_hblank_preset && xr_r[3:0] == `RRAG_BCD_LAST |=>
        o_cycle_code == `RRAG_OP_NOP)
        else $error("access cycle allowed in blanking");

endmodule : rrag_core

//--- rrag_seq_model.sv
// Sequencer and sync model: step pulses, blanking and timing selects.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps

module rrag_seq_model
    import rrag_pkg::*;
(
    input wire logic i_clk_sys,
    output logic o_x_step_pulse,
    output logic o_y_step_pulse,
    output logic o_hblank_preset,
    output logic o_vblank_preset,
    output rrag_tgen_t o_tgen
);
    initial begin
        o_x_step_pulse = 1'b0;
        o_y_step_pulse = 1'b0;
        o_hblank_preset = 1'b0;
        o_vblank_preset = 1'b0;
        o_tgen = '0;
    end

    task step(input logic x, input logic y);
        @(posedge i_clk_sys);
        o_x_step_pulse <= x;
        o_y_step_pulse <= y;
        @(posedge i_clk_sys);
        o_x_step_pulse <= 1'b0;
        o_y_step_pulse <= 1'b0;
    endtask : step

    task set_blank(input logic h);
        @(posedge i_clk_sys);
        o_hblank_preset <= h;
    endtask : set_blank

    task set_vblank(input logic v);
        @(posedge i_clk_sys);
        o_vblank_preset <= v;
    endtask : set_vblank

    task set_tgen(input rrag_tgen_t t);
        @(posedge i_clk_sys);
        o_tgen <= t;
    endtask : set_tgen

    // Short lines keep the run brief
    task lines(input int n);
        repeat (n) begin
            set_blank(1'b1);
            repeat (2) @(posedge i_clk_sys);
            o_hblank_preset <= 1'b0;
            repeat (10) @(posedge i_clk_sys);
        end
    endtask : lines
endmodule : rrag_seq_model

//--- tb_rrag_core.sv
// Self-checking bench of the refresh address generator.
// Assumes Avalon-MM timing of one wait cycle and the offsets of rrag_cfg.
`timescale 1ns/1ps

`include "rrag_cfg.svh"

module tb_rrag_core
    import rrag_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [4:0] i_address = 5'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'hf;
    logic key_a = 1'b1;
    logic key_b = 1'b1;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic xs, ys, hb, vb;
    rrag_tgen_t tg;
    logic [5:0] o_x_element_addr;
    logic o_access_field_bit;
    logic o_line_parity_bit;
    logic [3:0] o_state_timing;
    logic o_refresh_addr_bit;
    logic [5:0] o_ram_addr;
    logic [1:0] o_cycle_code;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] q;
    logic [1:0] keys [3] = '{2'h0, 2'h1, 2'h3};
    logic [9:0] x_exp [3] = '{10'h00a, 10'h004, 10'h005};
    logic [11:0] y_exp [3] = '{12'h006, 12'h006, 12'h003};
    int n;

    always #12.5 i_clk_sys = ~i_clk_sys;

    rrag_core u_rrag_core (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_x_step_pulse(xs), .i_y_step_pulse(ys),
        .i_resolution_key_a(key_a), .i_resolution_key_b(key_b),
        .i_hblank_preset(hb), .i_vblank_preset(vb), .i_tgen(tg),
        .o_x_element_addr(o_x_element_addr),
        .o_access_field_bit(o_access_field_bit),
        .o_line_parity_bit(o_line_parity_bit),
        .o_state_timing(o_state_timing),
        .o_refresh_addr_bit(o_refresh_addr_bit),
        .o_ram_addr(o_ram_addr), .o_cycle_code(o_cycle_code)
    );

    rrag_seq_model u_rrag_seq_model (
        .i_clk_sys(i_clk_sys), .o_x_step_pulse(xs), .o_y_step_pulse(ys),
        .o_hblank_preset(hb), .o_vblank_preset(vb), .o_tgen(tg)
    );

    task give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen,
                exp);
        end
    endtask : check

    // Holds the request until waitrequest is sampled low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int k;
        @(posedge i_clk_sys);
        i_write <= wr;
        i_read <= ~wr;
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= be;
        k = 0;
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            fail_count++;
            give_verdict();
        end
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus

    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask : wr

    task rd_check(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(q, exp);
    endtask : rd_check

    // Lets registered outputs settle before sampling
    task idle(input int c);
        repeat (c) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask : idle

    // Keys pass a two-stage synchroniser
    task set_res(input logic [1:0] k);
        @(posedge i_clk_sys);
        {key_a, key_b} <= k;
        idle(4);
    endtask : set_res

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check(32'(o_cycle_code), 32'h3);
        check(32'(o_waitrequest), 32'h1);
        @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        idle(3);
        rd_check(`RRAG_OFF_CTRL, 32'h0);
        bus(1'b0, `RRAG_OFF_STAT, 32'h0, 4'hf);
        check(32'(q[7:0]), 32'hc4);
        for (int i = 0; i < 3; i++) begin
            set_res(keys[i]);
            bus(1'b0, `RRAG_OFF_STAT, 32'h0, 4'hf);
            check(32'(q[2:1]), i);
            wr(`RRAG_OFF_XPT, 32'd5);
            wr(`RRAG_OFF_YPT, 32'd3);
            rd_check(`RRAG_OFF_XPT, 32'(x_exp[i]));
            rd_check(`RRAG_OFF_YPT, 32'(y_exp[i]));
        end
        wr(`RRAG_OFF_YPT, 32'd13);
        idle(1);
        check(32'(o_x_element_addr), 32'h05);
        check(32'(o_access_field_bit), 32'h1);
        u_rrag_seq_model.set_tgen(3'b111);
        idle(2);
        check(32'(o_ram_addr), 32'h01);
        u_rrag_seq_model.set_tgen(3'b110);
        idle(2);
        check(32'(o_ram_addr), 32'h20);
        u_rrag_seq_model.set_tgen(3'b101);
        idle(2);
        check(32'(o_ram_addr), 32'h20);
        wr(`RRAG_OFF_CTRL, 32'h3);
        wr(`RRAG_OFF_XPT, 32'd19);
        rd_check(`RRAG_OFF_XPT, 32'h013);
        u_rrag_seq_model.step(1'b1, 1'b0);
        rd_check(`RRAG_OFF_XPT, 32'h020);
        check(32'(o_x_element_addr), 32'h20);
        wr(`RRAG_OFF_CTRL, 32'h1);
        u_rrag_seq_model.step(1'b1, 1'b0);
        rd_check(`RRAG_OFF_XPT, 32'h013);
        wr(`RRAG_OFF_CTRL, 32'hc);
        u_rrag_seq_model.step(1'b1, 1'b1);
        rd_check(`RRAG_OFF_YPT, 32'h00e);
        rd_check(`RRAG_OFF_XPT, 32'h013);
        bus(1'b1, `RRAG_OFF_CTRL, 32'h0, 4'h0);
        rd_check(`RRAG_OFF_CTRL, 32'hc);
        // Move write supplies the equation for its own access cycle
        fork
            wr(`RRAG_OFF_MOVE, 32'h3);
            begin
                @(posedge i_clk_sys);
                u_rrag_seq_model.step(1'b1, 1'b0);
            end
        join
        rd_check(`RRAG_OFF_XPT, 32'h020);
        rd_check(`RRAG_OFF_CTRL, 32'hc);
        set_res(2'h0);
        wr(`RRAG_OFF_CTRL, 32'h7);
        wr(`RRAG_OFF_XPT, 32'd5);
        wr(`RRAG_OFF_YPT, 32'd7);
        u_rrag_seq_model.step(1'b1, 1'b1);
        rd_check(`RRAG_OFF_XPT, 32'h00c);
        rd_check(`RRAG_OFF_YPT, 32'h00d);
        set_res(2'h3);
        // Origin already offset by the host
        u_rrag_seq_model.set_blank(1'b1);
        wr(`RRAG_OFF_XORG, 32'd13);
        wr(`RRAG_OFF_YORG, 32'd5);
        rd_check(`RRAG_OFF_XORG, 32'h00d);
        rd_check(`RRAG_OFF_YORG, 32'h005);
        idle(2);
        check(32'(o_line_parity_bit), 32'h1);
        check(32'(o_state_timing), 32'h6);
        check(32'(o_refresh_addr_bit), 32'h0);
        wr(`RRAG_OFF_XORG, 32'd19);
        rd_check(`RRAG_OFF_XORG, 32'h00d);
        bus(1'b0, `RRAG_OFF_STAT, 32'h0, 4'hf);
        check(32'(q[0]), 32'h1);
        wr(`RRAG_OFF_STAT, 32'h1);
        bus(1'b0, `RRAG_OFF_STAT, 32'h0, 4'hf);
        check(32'(q[0]), 32'h0);
        u_rrag_seq_model.set_blank(1'b0);
        n = 0;
        while (o_state_timing !== 4'h9 && n < 12) begin
            idle(0);
            @(posedge i_clk_sys);
            n++;
        end
        idle(0);
        check(32'(o_state_timing), 32'h0);
        check(32'(o_refresh_addr_bit), 32'h1);
        u_rrag_seq_model.lines(12);
        wr(`RRAG_OFF_XORG, 32'd19);
        rd_check(`RRAG_OFF_XORG, 32'h013);
        for (int k = 0; k < 3; k++) begin
            wr(`RRAG_OFF_MEMOP, k);
            idle(22);
            check(32'(o_cycle_code), k);
            rd_check(`RRAG_OFF_MEMOP, 32'(k * 5));
        end
        // Y refresh follows its origin, then one step per line
        wr(`RRAG_OFF_YORG, 32'd20);
        u_rrag_seq_model.set_tgen(3'b011);
        u_rrag_seq_model.set_vblank(1'b1);
        idle(2);
        check(32'(o_ram_addr), 32'h05);
        u_rrag_seq_model.set_vblank(1'b0);
        u_rrag_seq_model.lines(4);
        idle(0);
        check(32'(o_ram_addr), 32'h06);
        u_rrag_seq_model.set_blank(1'b1);
        idle(2);
        check(32'(o_cycle_code), 32'h3);
        u_rrag_seq_model.set_blank(1'b0);
        give_verdict();
    end
endmodule : tb_rrag_core
